// ---- design/fsp_pin_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// carries the filtered write-guard pin level from synchroniser to core
interface fsp_pin_if;
    logic guard_level;
    modport sync (output guard_level);
    modport core (input guard_level);
endinterface
`default_nettype wire

// ---- design/fsp_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsp_pin_sync
    import fsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic pin_raw,
    fsp_pin_if.sync pin
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } fsp_sync_t;

    fsp_sync_t r;
    fsp_sync_t next_r;

    // level only moves once the second and third stages agree
    always_comb
    begin
        next_r = r;
        next_r.s1 = pin_raw;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        if (r.s2 == r.s3)
        begin
            next_r.level = r.s3;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            r <= '{s1: PIN_RESET_LEVEL, s2: PIN_RESET_LEVEL, s3: PIN_RESET_LEVEL, level: PIN_RESET_LEVEL};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign pin.guard_level = r.level;
endmodule
`default_nettype wire

// ---- design/fsp_pkg.sv ----
package fsp_pkg;
    // clock and timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SR_WRITE_US = 5;
    localparam logic [15:0] SR_WRITE_CYCLES = 16'(SR_WRITE_US * CLK_MHZ);

    // bit positions in the status and control word
    localparam int unsigned BIT_BUSY = 0;
    localparam int unsigned BIT_WEL = 1;
    localparam int unsigned BIT_REGION_LO = 2;
    localparam int unsigned BIT_GUARD_LO = 7;
    localparam int unsigned BIT_GUARD_HI = 8;
    localparam int unsigned BIT_QUAD = 9;
    localparam int unsigned BIT_WRITE_PAUSED = 10;
    localparam int unsigned BIT_LOCK_LO = 11;
    localparam int unsigned BIT_INVERT = 14;
    localparam int unsigned BIT_WIPE_PAUSED = 15;

    // values after reset
    localparam logic [4:0] REGION_RESET = 5'h00;
    localparam logic [2:0] LOCK_RESET = 3'h0;
    localparam logic PIN_RESET_LEVEL = 1'b1;
    localparam logic [15:0] PEND_RESET = 16'h0000;

    // opcodes
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_REG_STORE = 8'h01;
    localparam logic [7:0] OPC_PAGE_WRITE = 8'h02;
    localparam logic [7:0] OPC_SMALL_WIPE = 8'h20;
    localparam logic [7:0] OPC_BLOCK_WIPE_32 = 8'h52;
    localparam logic [7:0] OPC_BLOCK_WIPE_64 = 8'hD8;
    localparam logic [7:0] OPC_CHIP_WIPE_A = 8'hC7;
    localparam logic [7:0] OPC_CHIP_WIPE_B = 8'h60;
    localparam logic [7:0] OPC_SUSPEND = 8'h75;
    localparam logic [7:0] OPC_RESUME = 8'h7A;
    localparam logic [7:0] OPC_SEC_PROGRAM = 8'h42;
    localparam logic [7:0] OPC_SEC_WIPE = 8'h44;

    typedef enum logic [2:0] {OP_NONE, OP_PAGE, OP_WIPE, OP_CHIP, OP_SEC_PROG, OP_SEC_WIPE} fsp_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_SR_UPDATE, ST_ENGINE, ST_PAUSED} fsp_state_t;
endpackage

// ---- design/fsp_status_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsp_status_reg
    import fsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_byte_aligned,
    input wire logic [15:0] cmd_data,
    input wire logic target_protected,
    input wire logic [1:0] sec_index,
    input wire logic engine_done,
    input wire logic nv_restore,
    input wire logic [15:0] nv_image,
    input wire logic write_guard_pin,
    output logic [15:0] status_word,
    output logic op_start,
    output logic [2:0] op_kind,
    output logic op_pause,
    output logic op_resume,
    output logic cmd_refused,
    output logic quad_lanes_on,
    output logic [2:0] secure_area_lock,
    output logic [4:0] region_guard,
    output logic invert_region_flag
);
    typedef struct packed {
        fsp_state_t st;
        fsp_op_t kind;
        logic [15:0] timer;
        logic [15:0] pend;
        logic write_enable_latch;
        logic [4:0] region;
        logic reg_guard_hi;
        logic reg_guard_lo;
        logic quad;
        logic [2:0] lock;
        logic invert;
        logic write_paused_flag;
        logic wipe_paused_flag;
        logic start;
        logic pause;
        logic resume;
        logic refused;
    } fsp_core_t;

    fsp_core_t r;
    fsp_core_t next_r;
    fsp_pin_if pin_bus ();
    logic guard_pin_locks;
    logic store_ok;
    logic chip_ok;

    fsp_pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .pin_raw(write_guard_pin),
        .pin(pin_bus)
    );

    // store permission from guard mode and pin; store_ok adds the latch
    function automatic logic guard_allows(input logic hi, input logic lo, input logic pin_locks);
        unique case ({hi, lo})
            2'b00: guard_allows = 1'b1;
            2'b01: guard_allows = !pin_locks;
            2'b10: guard_allows = 1'b0;
            2'b11: guard_allows = 1'b0;
        endcase
    endfunction

    // with quad lanes on the pin is a data lane, so it cannot lock
    assign guard_pin_locks = !pin_bus.guard_level && !r.quad;
    assign store_ok = r.write_enable_latch && guard_allows(r.reg_guard_hi, r.reg_guard_lo, guard_pin_locks);
    assign chip_ok = ((r.region[2:0] == 3'h0) && !r.invert) || ((r.region[2:0] == 3'h7) && r.invert);

    always_comb
    begin
        next_r = r;
        next_r.start = 1'b0;
        next_r.pause = 1'b0;
        next_r.resume = 1'b0;
        next_r.refused = 1'b0;
        unique case (r.st)
            ST_IDLE:
            begin
                if (cmd_valid && !cmd_byte_aligned)
                    next_r.refused = 1'b1;
                else if (cmd_valid)
                begin
                    if (cmd_code == OPC_WRITE_ENABLE)
                        next_r.write_enable_latch = 1'b1;
                    else if (cmd_code == OPC_WRITE_DISABLE)
                        next_r.write_enable_latch = 1'b0;
                    else if (cmd_code == OPC_REG_STORE)
                    begin
                        if (store_ok)
                        begin
                            next_r.st = ST_SR_UPDATE;
                            next_r.timer = SR_WRITE_CYCLES;
                            next_r.pend = cmd_data;
                        end
                        else
                            next_r.refused = 1'b1;
                    end
                    else if ((cmd_code == OPC_PAGE_WRITE) || (cmd_code == OPC_SMALL_WIPE)
                             || (cmd_code == OPC_BLOCK_WIPE_32) || (cmd_code == OPC_BLOCK_WIPE_64))
                    begin
                        if (r.write_enable_latch && !target_protected)
                        begin
                            next_r.st = ST_ENGINE;
                            next_r.start = 1'b1;
                            next_r.kind = (cmd_code == OPC_PAGE_WRITE) ? OP_PAGE : OP_WIPE;
                            next_r.write_enable_latch = 1'b0;
                        end
                        else
                            next_r.refused = 1'b1;
                    end
                    else if ((cmd_code == OPC_CHIP_WIPE_A) || (cmd_code == OPC_CHIP_WIPE_B))
                    begin
                        if (r.write_enable_latch && chip_ok)
                        begin
                            next_r.st = ST_ENGINE;
                            next_r.start = 1'b1;
                            next_r.kind = OP_CHIP;
                            next_r.write_enable_latch = 1'b0;
                        end
                        else
                            next_r.refused = 1'b1;
                    end
                    else if ((cmd_code == OPC_SEC_PROGRAM) || (cmd_code == OPC_SEC_WIPE))
                    begin
                        // a locked security area is read-only
                        if (r.write_enable_latch && (sec_index != 2'h3) && !r.lock[sec_index])
                        begin
                            next_r.st = ST_ENGINE;
                            next_r.start = 1'b1;
                            next_r.kind = (cmd_code == OPC_SEC_PROGRAM) ? OP_SEC_PROG : OP_SEC_WIPE;
                            next_r.write_enable_latch = 1'b0;
                        end
                        else
                            next_r.refused = 1'b1;
                    end
                end
            end
            ST_SR_UPDATE:
            begin
                // commands are ignored during a register store; new bits appear only at the end
                next_r.timer = r.timer - 16'h0001;
                if (r.timer == 16'h0001)
                begin
                    next_r.st = ST_IDLE;
                    next_r.write_enable_latch = 1'b0;
                    if (!(r.reg_guard_lo && !r.reg_guard_hi && guard_pin_locks))
                        next_r.region = r.pend[BIT_REGION_LO +: 5];
                    next_r.reg_guard_lo = r.pend[BIT_GUARD_LO];
                    next_r.reg_guard_hi = r.pend[BIT_GUARD_HI];
                    next_r.quad = r.pend[BIT_QUAD];
                    next_r.lock = r.lock | r.pend[BIT_LOCK_LO +: 3];
                    next_r.invert = r.pend[BIT_INVERT];
                end
            end
            ST_ENGINE:
            begin
                if (engine_done)
                begin
                    next_r.st = ST_IDLE;
                    next_r.kind = OP_NONE;
                end
                else if (cmd_valid && (cmd_code == OPC_SUSPEND) && ((r.kind == OP_PAGE) || (r.kind == OP_WIPE)))
                begin
                    next_r.st = ST_PAUSED;
                    next_r.pause = 1'b1;
                    next_r.write_paused_flag = (r.kind == OP_PAGE);
                    next_r.wipe_paused_flag = (r.kind == OP_WIPE);
                end
            end
            ST_PAUSED:
            begin
                if (cmd_valid && (cmd_code == OPC_RESUME))
                begin
                    next_r.st = ST_ENGINE;
                    next_r.resume = 1'b1;
                    next_r.write_paused_flag = 1'b0;
                    next_r.wipe_paused_flag = 1'b0;
                end
            end
        endcase
        // power-up image load wins over everything but srst; volatile state starts clear
        if (nv_restore)
        begin
            next_r = '0;
            next_r.st = ST_IDLE;
            next_r.kind = OP_NONE;
            next_r.region = nv_image[BIT_REGION_LO +: 5];
            next_r.quad = nv_image[BIT_QUAD];
            next_r.lock = nv_image[BIT_LOCK_LO +: 3];
            next_r.invert = nv_image[BIT_INVERT];
            if (!(nv_image[BIT_GUARD_HI] && !nv_image[BIT_GUARD_LO]))
            begin
                next_r.reg_guard_hi = nv_image[BIT_GUARD_HI];
                next_r.reg_guard_lo = nv_image[BIT_GUARD_LO];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.kind <= OP_NONE;
            r.pend <= PEND_RESET;
            r.region <= REGION_RESET;
            r.lock <= LOCK_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    // status word assembled from stored fields; busy decoded from state
    assign status_word = {r.wipe_paused_flag, r.invert, r.lock, r.write_paused_flag, r.quad, r.reg_guard_hi,
                          r.reg_guard_lo, r.region, r.write_enable_latch,
                          (r.st == ST_SR_UPDATE) || (r.st == ST_ENGINE)};
    assign op_start = r.start;
    assign op_kind = r.kind;
    assign op_pause = r.pause;
    assign op_resume = r.resume;
    assign cmd_refused = r.refused;
    assign quad_lanes_on = r.quad;
    assign secure_area_lock = r.lock;
    assign region_guard = r.region;
    assign invert_region_flag = r.invert;
    // launch pulse and busy flag come from different fields, but both are set in the same cycle
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || nv_restore);
    a_busy_flag: assert property (op_start |-> status_word[BIT_BUSY] && !status_word[BIT_WEL])
        else $error("busy flag low during operation");
    a_idle_flag: assert property ((r.st == ST_ENGINE) && engine_done |=> !status_word[BIT_BUSY] && (op_kind == 3'h0))
        else $error("busy flag high while idle");
    a_latch_refuse: assert property (cmd_valid && cmd_byte_aligned && (cmd_code == OPC_REG_STORE) && (r.st == ST_IDLE)
        && !r.write_enable_latch |=> cmd_refused && (r.st == ST_IDLE))
        else $error("store taken with latch clear");
    a_region_refuse: assert property (cmd_valid && cmd_byte_aligned && (cmd_code == OPC_PAGE_WRITE) && (r.st == ST_IDLE)
        && target_protected |=> cmd_refused && !op_start)
        else $error("write into protected region");
    a_chip_guard: assert property (cmd_valid && cmd_byte_aligned && (cmd_code == OPC_CHIP_WIPE_A) && (r.st == ST_IDLE)
        && r.write_enable_latch && !chip_ok |=> cmd_refused)
        else $error("chip wipe with mixed guard bits");
    a_soft_store: assert property (cmd_valid && cmd_byte_aligned && (cmd_code == OPC_REG_STORE) && (r.st == ST_IDLE)
        && r.write_enable_latch && !r.reg_guard_hi && !r.reg_guard_lo |=> (r.st == ST_SR_UPDATE))
        else $error("store refused in software mode");
    a_pin_lock: assert property (cmd_valid && cmd_byte_aligned && (cmd_code == OPC_REG_STORE) && (r.st == ST_IDLE)
        && !r.reg_guard_hi && r.reg_guard_lo && guard_pin_locks |=> cmd_refused)
        else $error("store taken while pin locked");
    a_guard_hi_lock: assert property (cmd_valid && (cmd_code == OPC_REG_STORE) && (r.st == ST_IDLE) && r.reg_guard_hi
        |=> (r.st == ST_IDLE) ##1 (r.st != ST_SR_UPDATE))
        else $error("store taken in lock-down mode");
    a_lock_sticky: assert property (!$past(nv_restore) && !$past(srst) |-> (($past(r.lock) & ~r.lock) == 3'h0))
        else $error("lock bit cleared");
    a_pause_flag: assert property (cmd_valid && (cmd_code == OPC_SUSPEND) && (r.st == ST_ENGINE) && !engine_done
        && (r.kind == OP_WIPE) |=> status_word[BIT_WIPE_PAUSED] && !status_word[BIT_BUSY])
        else $error("wipe suspend flag missing");
    a_resume_clear: assert property (cmd_valid && (cmd_code == OPC_RESUME) && (r.st == ST_PAUSED)
        |=> !r.wipe_paused_flag && !r.write_paused_flag && op_resume)
        else $error("pause flags not cleared");
    a_unaligned: assert property (cmd_valid && !cmd_byte_aligned && (r.st == ST_IDLE)
        |=> cmd_refused && !op_start && (r.st == ST_IDLE))
        else $error("unaligned command executed");
    a_store_end: assert property ((r.st == ST_SR_UPDATE) && (r.timer == 16'h0001)
        |=> (r.st == ST_IDLE) && !status_word[BIT_WEL] && !status_word[BIT_BUSY])
        else $error("store did not finish cleanly");
    a_store_timer: assert property ((r.st == ST_SR_UPDATE) |-> (r.timer != 16'h0000) && (r.timer <= SR_WRITE_CYCLES))
        else $error("store timer out of range");
endmodule
`default_nettype wire

// ---- sim/fsp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host controller side: hands over whole decoded commands, one at a time
module fsp_host_model
(
    input wire logic ref_clk,
    input wire logic cmd_refused,
    input wire logic op_start,
    input wire logic op_pause,
    input wire logic op_resume,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic cmd_byte_aligned,
    output logic [15:0] cmd_data
);
    // idle bus at time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        cmd_byte_aligned = 1'b1;
        cmd_data = 16'h0000;
    end

    // one command pulse, then gather answer pulses over three cycles
    task automatic issue(input logic [7:0] c, input logic [15:0] d, input logic a, output logic [3:0] seen);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_byte_aligned = a; // only a deliberate fault ends off a byte
        cmd_data = d;
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b0;
        cmd_code = ~c; // released lines must not keep the old opcode
        cmd_data = ~d;
        seen = 4'h0;
        repeat (3)
        begin
            seen = seen | {cmd_refused, op_start, op_pause, op_resume};
            @(posedge ref_clk);
            #1;
        end
    endtask
endmodule
`default_nettype wire

// ---- sim/tb_flash_status_protect_reg.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_flash_status_protect_reg
    import fsp_pkg::*;
;
    logic ref_clk;
    logic srst;
    logic target_protected, engine_done, nv_restore, write_guard_pin;
    logic [1:0] sec_index;
    logic [15:0] nv_image;
    logic cmd_valid, cmd_byte_aligned;
    logic [7:0] cmd_code;
    logic [15:0] cmd_data;
    logic [15:0] status_word;
    logic op_start, op_pause, op_resume, cmd_refused, quad_lanes_on, invert_region_flag;
    logic [2:0] op_kind;
    logic [2:0] secure_area_lock;
    logic [4:0] region_guard;
    logic [3:0] seen;
    int failures = 0;
    int tests_run = 0;
    int cyc = 0;

    fsp_status_reg DUT (.ref_clk(ref_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_byte_aligned(cmd_byte_aligned), .cmd_data(cmd_data), .target_protected(target_protected),
        .sec_index(sec_index), .engine_done(engine_done), .nv_restore(nv_restore), .nv_image(nv_image),
        .write_guard_pin(write_guard_pin), .status_word(status_word), .op_start(op_start),
        .op_kind(op_kind), .op_pause(op_pause), .op_resume(op_resume), .cmd_refused(cmd_refused),
        .quad_lanes_on(quad_lanes_on), .secure_area_lock(secure_area_lock),
        .region_guard(region_guard), .invert_region_flag(invert_region_flag));

    fsp_host_model host (.ref_clk(ref_clk), .cmd_refused(cmd_refused), .op_start(op_start),
        .op_pause(op_pause), .op_resume(op_resume), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_byte_aligned(cmd_byte_aligned), .cmd_data(cmd_data));

    // 100 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // hang guard, well above the seven stores the run needs
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // answer code is {refused, start, pause, resume}
    task automatic ans(input logic [3:0] e);
        chk("answer", {12'h000, e}, {12'h000, seen});
    endtask

    function automatic logic [15:0] sd(input logic inv, input logic [2:0] lk, input logic q,
        input logic [1:0] g, input logic [4:0] rg);
        return {1'b0, inv, lk, 1'b0, q, g, rg, 2'b00};
    endfunction

    task automatic cmd(input logic [7:0] c, input logic [15:0] d = 16'h0000, input logic a = 1'b1);
        host.issue(c, d, a, seen);
    endtask

    // bounded wait for the busy bit to drop
    task automatic wait_idle();
        for (int i = 0; i < 700 && status_word[0] !== 1'b0; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic store(input logic [15:0] d);
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_REG_STORE, d);
        wait_idle();
    endtask

    task automatic finish_op();
        engine_done = 1'b1;
        @(posedge ref_clk);
        #1;
        engine_done = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic restore(input logic [15:0] img);
        nv_restore = 1'b1;
        nv_image = img;
        @(posedge ref_clk);
        #1;
        nv_restore = 1'b0;
        nv_image = ~img;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    task automatic s_latch();
        chk("reset word", 16'h0000, status_word);
        cmd(OPC_REG_STORE, sd(1, 3'h7, 1, 2'h3, 5'h1F));
        ans(4'h8);
        cmd(OPC_PAGE_WRITE);
        ans(4'h8);
        cmd(OPC_WRITE_ENABLE);
        chk("latch", 16'h0002, status_word);
        cmd(OPC_WRITE_DISABLE);
        chk("latch", 16'h0000, status_word);
    endtask

    task automatic s_store();
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_REG_STORE, sd(1, 3'h2, 1, 2'h0, 5'h15));
        ans(4'h0);
        chk("busy store", 16'h0003, status_word);
        wait_idle();
        chk("word", sd(1, 3'h2, 1, 2'h0, 5'h15), status_word);
        chk("fields", {7'h00, 1'b1, 3'h2, 5'h15}, {7'h00, quad_lanes_on, secure_area_lock, region_guard});
        chk("invert", 16'h0001, {15'h0000, invert_region_flag});
        store(sd(0, 3'h0, 0, 2'h1, 5'h00));
        chk("locks kept", sd(0, 3'h2, 0, 2'h1, 5'h00), status_word);
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_REG_STORE, sd(0, 3'h0, 0, 2'h1, 5'h07), 1'b0);
        ans(4'h8);
    endtask

    task automatic s_pin();
        write_guard_pin = 1'b0;
        repeat (6) @(posedge ref_clk);
        #1;
        store(sd(0, 3'h0, 0, 2'h1, 5'h07));
        ans(4'h8);
        chk("region", 16'h0000, {11'h000, region_guard});
        write_guard_pin = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        store(sd(0, 3'h0, 0, 2'h1, 5'h07));
        chk("word", sd(0, 3'h2, 0, 2'h1, 5'h07), status_word);
    endtask

    task automatic s_chip();
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_CHIP_WIPE_A);
        ans(4'h8);
        store(sd(0, 3'h0, 0, 2'h0, 5'h18));
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_CHIP_WIPE_B);
        ans(4'h4);
        chk("kind", 16'h0003, {13'h0000, op_kind});
        chk("busy op", 16'h0001, status_word[15:0] & 16'h0003);
        finish_op();
        chk("idle", 16'h0000, {15'h0000, status_word[0]});
        store(sd(1, 3'h0, 0, 2'h0, 5'h07));
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_CHIP_WIPE_A);
        ans(4'h4);
        finish_op();
    endtask

    task automatic s_suspend();
        target_protected = 1'b1;
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_PAGE_WRITE);
        ans(4'h8);
        cmd(OPC_BLOCK_WIPE_32);
        ans(4'h8);
        target_protected = 1'b0;
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_PAGE_WRITE);
        ans(4'h4);
        chk("kind", 16'h0001, {13'h0000, op_kind});
        cmd(OPC_SUSPEND);
        ans(4'h2);
        chk("paused", 16'h0400, status_word & 16'h8403);
        cmd(OPC_RESUME);
        ans(4'h1);
        chk("resumed", 16'h0001, status_word & 16'h8403);
        finish_op();
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_BLOCK_WIPE_64);
        ans(4'h4);
        chk("kind", 16'h0002, {13'h0000, op_kind});
        finish_op();
    endtask

    task automatic s_power();
        store(sd(0, 3'h0, 0, 2'h2, 5'h03));
        chk("word", sd(0, 3'h2, 0, 2'h2, 5'h03), status_word);
        store(sd(0, 3'h0, 0, 2'h0, 5'h00));
        ans(4'h8);
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_SMALL_WIPE);
        chk("kind", 16'h0002, {13'h0000, op_kind});
        cmd(OPC_SUSPEND);
        chk("wipe paused", 16'h8000, status_word & 16'h8401);
        restore(sd(0, 3'h2, 0, 2'h2, 5'h03) | 16'h8400);
        chk("power up", sd(0, 3'h2, 0, 2'h0, 5'h03), status_word);
    endtask

    task automatic s_otp();
        sec_index = 2'h1;
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_SEC_PROGRAM);
        ans(4'h8);
        sec_index = 2'h0;
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_SEC_PROGRAM);
        ans(4'h4);
        chk("kind", 16'h0004, {13'h0000, op_kind});
        finish_op();
        sec_index = 2'h3;
        cmd(OPC_WRITE_ENABLE);
        cmd(OPC_SEC_WIPE);
        ans(4'h8);
        sec_index = 2'h2;
        cmd(OPC_SEC_WIPE);
        ans(4'h4);
        chk("kind", 16'h0005, {13'h0000, op_kind});
        chk("busy op", 16'h0001, status_word & 16'h0003);
        finish_op();
        store(sd(0, 3'h0, 0, 2'h3, 5'h00));
        store(sd(0, 3'h0, 0, 2'h0, 5'h01));
        ans(4'h8);
        restore(sd(0, 3'h2, 0, 2'h3, 5'h00));
        store(sd(0, 3'h0, 0, 2'h0, 5'h01));
        ans(4'h8);
        chk("word", sd(0, 3'h2, 0, 2'h3, 5'h00), status_word & 16'hFFFD);
    endtask

    // reset, then the scenarios in a state-carrying order
    initial
    begin
        srst = 1'b1;
        target_protected = 1'b0;
        sec_index = 2'h0;
        engine_done = 1'b0;
        nv_restore = 1'b0;
        nv_image = 16'h0000;
        write_guard_pin = 1'b1; // driven, never tied, so quad lanes stay safe
        repeat (10) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        s_latch();
        s_store();
        s_pin();
        s_chip();
        s_suspend();
        s_power();
        s_otp();
        complete_run();
    end
endmodule
`default_nettype wire
